// [shared/ccrb_regs.svh]
// register offsets, field positions, reset values, masks and current step of the coil driver register bank
`ifndef CCRB_REGS_SVH
`define CCRB_REGS_SVH
`define CCRB_OFF_UNUSED 8'h01
`define CCRB_OFF_CONTROL 8'h02
`define CCRB_OFF_CUR_HIGH 8'h03
`define CCRB_OFF_CUR_LOW 8'h04
`define CCRB_OFF_STATUS 8'h05
`define CCRB_OFF_MODE 8'h06
`define CCRB_OFF_RESONANCE 8'h07
`define CCRB_BIT_SWRESET 0
`define CCRB_BIT_RINGEN 1
`define CCRB_RST_CONTROL 8'h02
`define CCRB_RST_CUR_HIGH 8'h00
`define CCRB_RST_CUR_LOW 8'h00
`define CCRB_RST_STATUS 8'h00
`define CCRB_RST_MODE 8'h00
`define CCRB_RST_RESONANCE 8'h83
`define CCRB_MASK_CUR_HIGH 8'h03
`define CCRB_MASK_MODE 8'h1F
`define CCRB_MASK_STATUS 8'h1F
`define CCRB_STEP_UA 100
`endif

// [shared/ccrb_pkg.sv]
// types shared by the coil driver register bank
`default_nettype none
package ccrb_pkg;
    // operating mode of the driver, one-hot
    typedef enum logic [1:0] {
        CCRB_STANDBY = 2'b01,
        CCRB_ACTIVE = 2'b10
    } ccrb_mode_e;
    typedef logic [9:0] ccrb_setpoint_t;
endpackage : ccrb_pkg
`default_nettype wire

// [core/ccrb_sync.sv]
// three-flop synchroniser for a level that arrives from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module ccrb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic refClk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1Q; // metastability catcher, read only by stage2Q
    logic [WIDTH-1:0] stage2Q;
    logic [WIDTH-1:0] stage3Q;

    // shift chain; output moves only when the last two stages agree
    always_ff @(posedge refClk) begin
        if (!rstN) begin
            stage1Q <= '0;
            stage2Q <= '0;
            stage3Q <= '0;
            syncOut <= '0;
        end else begin
            stage1Q <= asyncIn;
            stage2Q <= stage1Q;
            stage3Q <= stage2Q;
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2Q[i] == stage3Q[i]) begin
                    syncOut[i] <= stage3Q[i];
                end
            end
        end
    end
endmodule : ccrb_sync
`default_nettype wire

// [core/ccrb_bank.sv]
// register bank of the voice coil motor driver, written by the serial interface front end
// Behaviour
// - software reset restores defaults and enters standby
// - software reset bit clears itself, reads zero
// - offset 03 holds setpoint bits nine and eight
// - offset 04 holds setpoint low byte, resets zero
// - setpoint is linear, 0.1 mA per code
// - current applies only after low register write
// - zero setpoint means standby, output stage off
// - nonzero setpoint means active, output stage on
// - fault return to standby clears setpoint registers
`timescale 1ns/1ns
`default_nettype none
`include "ccrb_regs.svh"
module ccrb_bank (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRvalid,
    input wire logic [4:0] faultIn,
    output logic [9:0] coilCurrentSetpoint,
    output logic [16:0] coilCurrentMicroamp,
    output logic outputStageEnable,
    output logic ringCompEnable,
    output logic [1:0] driverModeState,
    output logic [7:0] driverModeBits,
    output logic [7:0] resonanceSetting
);
    logic ringEn_q; // ringing compensation enable
    logic [1:0] curHigh_q; // held high setpoint bits
    logic [7:0] curLow_q; // low setpoint byte
    logic [4:0] status_q; // sticky fault flags
    logic [4:0] mode_q;
    logic [7:0] resonance_q;
    logic swReset; // software reset strobe
    logic [4:0] faultSync; // faults after synchroniser
    logic faultHit; // fault seen while active
    logic [9:0] applied_d;
    ccrb_pkg::ccrb_mode_e mode_st_q;
    // control default held as a vector so the ring enable bit can be sliced out of it
    localparam logic [7:0] CtrlDefault = `CCRB_RST_CONTROL;

    // fault pins come from the analog side, so they are synchronised first
    ccrb_sync #(.WIDTH(5)) uFaultSync (
        .refClk(ref_clk),
        .rstN(rst_n),
        .asyncIn(faultIn),
        .syncOut(faultSync)
    );

    // writing one to the reset bit of the control register is a one-cycle strobe; never stored
    assign swReset = regWrite && regAddr == `CCRB_OFF_CONTROL && regWdata[`CCRB_BIT_SWRESET];
    assign faultHit = (mode_st_q == ccrb_pkg::CCRB_ACTIVE) && (|faultSync);

    // scale a code to microamps; linear in 0.1 mA steps
    // full scale is 102300 uA, so seventeen bits are needed to avoid wrapping
    function automatic logic [16:0] ccrb_to_ua(input logic [9:0] code);
        ccrb_to_ua = 17'(code) * 17'(`CCRB_STEP_UA);
    endfunction : ccrb_to_ua

    // control register; software reset returns ring enable to its default
    always_ff @(posedge ref_clk) begin
        if (!rst_n || swReset) begin
            ringEn_q <= CtrlDefault[`CCRB_BIT_RINGEN];
        end else if (regWrite && regAddr == `CCRB_OFF_CONTROL) begin
            ringEn_q <= regWdata[`CCRB_BIT_RINGEN];
        end
    end

    // setpoint registers; a fault drop to standby wipes them
    always_ff @(posedge ref_clk) begin
        if (!rst_n || swReset || faultHit) begin
            curHigh_q <= 2'(`CCRB_RST_CUR_HIGH);
            curLow_q <= `CCRB_RST_CUR_LOW;
        end else if (regWrite && regAddr == `CCRB_OFF_CUR_HIGH) begin
            curHigh_q <= regWdata[1:0];
        end else if (regWrite && regAddr == `CCRB_OFF_CUR_LOW) begin
            curLow_q <= regWdata;
        end
    end

    // the applied current only moves on a low register write, a software reset or a fault; a lone high write is held
    always_comb begin
        applied_d = coilCurrentSetpoint;
        if (swReset || faultHit) begin
            applied_d = '0;
        end else if (regWrite && regAddr == `CCRB_OFF_CUR_LOW) begin
            applied_d = {curHigh_q, regWdata};
        end
    end

    // applied setpoint, its current in microamps, and the output stage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            coilCurrentSetpoint <= '0;
            coilCurrentMicroamp <= '0;
            outputStageEnable <= 1'b0;
        end else begin
            coilCurrentSetpoint <= applied_d;
            coilCurrentMicroamp <= ccrb_to_ua(applied_d);
            outputStageEnable <= applied_d != '0;
        end
    end

    // mode machine tracks the applied setpoint
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_st_q <= ccrb_pkg::CCRB_STANDBY;
        end else begin
            case (mode_st_q)
                ccrb_pkg::CCRB_STANDBY: begin
                    if (applied_d != '0) begin
                        mode_st_q <= ccrb_pkg::CCRB_ACTIVE;
                    end
                end
                ccrb_pkg::CCRB_ACTIVE: begin
                    if (applied_d == '0) begin
                        mode_st_q <= ccrb_pkg::CCRB_STANDBY;
                    end
                end
                default: mode_st_q <= ccrb_pkg::CCRB_STANDBY;
            endcase
        end
    end

    // status flags are sticky; cleared on entry to active, but a new fault wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n || swReset) begin
            status_q <= 5'(`CCRB_RST_STATUS);
        end else if (mode_st_q == ccrb_pkg::CCRB_STANDBY && applied_d != '0) begin
            status_q <= faultSync;
        end else begin
            status_q <= status_q | faultSync;
        end
    end

    // mode and resonance registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n || swReset) begin
            mode_q <= 5'(`CCRB_RST_MODE);
            resonance_q <= `CCRB_RST_RESONANCE;
        end else if (regWrite && regAddr == `CCRB_OFF_MODE) begin
            mode_q <= regWdata[4:0];
        end else if (regWrite && regAddr == `CCRB_OFF_RESONANCE) begin
            resonance_q <= regWdata;
        end
    end

    // read port; unused bits and unknown offsets return zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdata <= '0;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            case (regAddr)
                `CCRB_OFF_CONTROL: regRdata <= {6'h00, ringEn_q, 1'b0};
                `CCRB_OFF_CUR_HIGH: regRdata <= {6'h00, curHigh_q};
                `CCRB_OFF_CUR_LOW: regRdata <= curLow_q;
                `CCRB_OFF_STATUS: regRdata <= {3'h0, status_q};
                `CCRB_OFF_MODE: regRdata <= {3'h0, mode_q};
                `CCRB_OFF_RESONANCE: regRdata <= resonance_q;
                default: regRdata <= 8'h00;
            endcase
        end
    end

    // mirrors to the analog side
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ringCompEnable <= 1'b0;
            driverModeState <= ccrb_pkg::CCRB_STANDBY;
            driverModeBits <= '0;
            resonanceSetting <= '0;
        end else begin
            ringCompEnable <= ringEn_q;
            driverModeState <= mode_st_q;
            driverModeBits <= {3'h0, mode_q};
            resonanceSetting <= resonance_q;
        end
    end

    // a lone high write leaves the applied current alone
    a_high_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regWrite && regAddr == `CCRB_OFF_CUR_HIGH && !faultHit) |=> $stable(coilCurrentSetpoint))
        else $error("high write changed applied current");
    // low write applies the combined code next cycle
    a_low_apply: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regWrite && regAddr == `CCRB_OFF_CUR_LOW && !swReset && !faultHit)
        |=> coilCurrentSetpoint == {$past(curHigh_q), $past(regWdata)})
        else $error("low write did not apply setpoint");
    // software reset returns control, setpoint, mode and resonance registers to defaults and turns the output stage off
    a_swreset_dflt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        swReset |=> (ringEn_q && curLow_q == `CCRB_RST_CUR_LOW && curHigh_q == 2'b00
            && resonance_q == `CCRB_RST_RESONANCE && mode_q == 5'(`CCRB_RST_MODE)
            && !outputStageEnable && coilCurrentSetpoint == 10'h000))
        else $error("software reset left state");
    // reset bit never reads back high
    a_swreset_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regRead && regAddr == `CCRB_OFF_CONTROL) |=> !regRdata[0])
        else $error("reset bit read as one");
    // high register upper bits read zero
    a_high_rdzero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regAddr == `CCRB_OFF_CUR_HIGH) |=> regRdata[7:2] == 6'h00)
        else $error("high register upper bits nonzero");
    // low register reads back what was written
    a_low_rdback: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regWrite && regAddr == `CCRB_OFF_CUR_LOW && !swReset && !faultHit) ##1
        (regAddr == `CCRB_OFF_CUR_LOW) |=> regRdata == $past(regWdata, 2))
        else $error("low register readback wrong");
    // microamp output tracks the code
    a_scale_ua: assert property (@(posedge ref_clk) disable iff (!rst_n)
        coilCurrentMicroamp == 17'(coilCurrentSetpoint) * 17'd100)
        else $error("current scale wrong");
    // stage on exactly when setpoint nonzero
    a_stage_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        outputStageEnable == (coilCurrentSetpoint != 10'h000))
        else $error("output stage mismatch");
    // active mode follows a nonzero apply
    a_enter_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (applied_d != 10'h000) |=> mode_st_q == ccrb_pkg::CCRB_ACTIVE)
        else $error("did not go active");
    // fault wipes setpoint
    a_fault_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        faultHit |=> (curLow_q == 8'h00 && curHigh_q == 2'b00 && coilCurrentSetpoint == 10'h000))
        else $error("fault did not clear setpoint");
    // offset one reads zero
    a_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regAddr == `CCRB_OFF_UNUSED) |=> regRdata == 8'h00)
        else $error("unused offset not zero");

    c_go_active: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(outputStageEnable));
    c_fault_drop: cover property (@(posedge ref_clk) disable iff (!rst_n) faultHit);
    c_sw_reset: cover property (@(posedge ref_clk) disable iff (!rst_n) swReset ##1 !outputStageEnable);
endmodule : ccrb_bank
`default_nettype wire

// [verification/ccrb_host_model.sv]
// serial front end model that issues register writes and reads to the bank
`timescale 1ns/1ns
`default_nettype none
`include "ccrb_regs.svh"
module ccrb_host_model (
    input wire logic ref_clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid
);
    // quiet bus from time zero
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'hA5;
    end
    // one write pulse; data inverted after so a stale byte never looks valid
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge ref_clk);
        regWrite = 1'b0;
        regWdata = ~d;
    endtask : wrReg
    // one read pulse; answer taken a cycle later while address is held
    task automatic rdReg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge ref_clk);
        regRead = 1'b0;
        d = regRdata;
        v = regRvalid;
    endtask : rdReg
    // a current change always writes high then low
    task automatic setCur(input logic [9:0] c);
        wrReg(`CCRB_OFF_CUR_HIGH, {6'h00, c[9:8]});
        wrReg(`CCRB_OFF_CUR_LOW, c[7:0]);
    endtask : setCur
endmodule : ccrb_host_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the coil driver register bank
`timescale 1ns/1ns
`default_nettype none
`include "ccrb_regs.svh"
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] faultIn = 5'h00; // fault levels driven by the bench
    wire logic [7:0] regAddr, regWdata, regRdata, modeBits, reso;
    wire logic regWrite, regRead, regRvalid, outEn, ringEn;
    wire logic [9:0] setpoint;
    wire logic [16:0] microamp;
    wire logic [1:0] modeState;
    int err_total = 0;
    int comparisons = 0;
    logic [7:0] d;
    logic v;
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    ccrb_bank dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .faultIn(faultIn), .coilCurrentSetpoint(setpoint), .coilCurrentMicroamp(microamp),
        .outputStageEnable(outEn), .ringCompEnable(ringEn), .driverModeState(modeState),
        .driverModeBits(modeBits), .resonanceSetting(reso));
    ccrb_host_model host_u (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
    // one comparison, mismatch reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // read one register and judge value and valid flag
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        host_u.rdReg(a, d, v);
        chk(v, 1'b1);
        chk(d, exp);
    endtask : rdChk
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    // reset values, unused slot and an unmapped offset
    task automatic test_defaults();
        logic [7:0] exp [7] = '{8'h00, `CCRB_RST_CONTROL, `CCRB_RST_CUR_HIGH, `CCRB_RST_CUR_LOW,
            `CCRB_RST_STATUS, `CCRB_RST_MODE, `CCRB_RST_RESONANCE};
        for (int i = 0; i < 7; i++) begin
            rdChk(8'(i + 1), exp[i]);
        end
        rdChk(8'h08, 8'h00);
        host_u.wrReg(`CCRB_OFF_UNUSED, 8'hFF);
        rdChk(`CCRB_OFF_UNUSED, 8'h00);
        chk(reso, `CCRB_RST_RESONANCE);
        chk(ringEn, 1'b1);
        chk(modeState, ccrb_pkg::CCRB_STANDBY);
        chk(outEn, 1'b0);
        $display("test_defaults done");
    endtask : test_defaults
    // high write alone is held; low write applies the pair
    task automatic test_current();
        host_u.wrReg(`CCRB_OFF_CUR_HIGH, 8'hFF);
        idle(3);
        chk(setpoint, 10'h000);
        rdChk(`CCRB_OFF_CUR_HIGH, 8'h03);
        host_u.wrReg(`CCRB_OFF_CUR_LOW, 8'hF4);
        idle(3);
        chk(setpoint, 10'h3F4);
        chk(microamp, 17'd101200);
        chk(outEn, 1'b1);
        chk(modeState, ccrb_pkg::CCRB_ACTIVE);
        host_u.setCur(10'h0A3);
        idle(3);
        chk(microamp, 17'd16300);
        host_u.setCur(10'h000);
        idle(3);
        chk(outEn, 1'b0);
        chk(modeState, ccrb_pkg::CCRB_STANDBY);
        $display("test_current done");
    endtask : test_current
    // software reset from active: defaults, standby, bit reads zero
    task automatic test_swreset();
        host_u.wrReg(`CCRB_OFF_CONTROL, 8'h00);
        host_u.wrReg(`CCRB_OFF_MODE, 8'hFF);
        host_u.setCur(10'h1F4);
        host_u.wrReg(`CCRB_OFF_RESONANCE, 8'h40);
        idle(2);
        rdChk(`CCRB_OFF_CONTROL, 8'h00);
        chk(ringEn, 1'b0);
        rdChk(`CCRB_OFF_MODE, 8'h1F);
        chk(modeBits, 8'h1F);
        chk(reso, 8'h40);
        chk(microamp, 17'd50000);
        host_u.wrReg(`CCRB_OFF_CONTROL, 8'h01);
        idle(3);
        chk(setpoint, 10'h000);
        chk(modeState, ccrb_pkg::CCRB_STANDBY);
        chk(ringEn, 1'b1);
        chk(modeBits, 8'h00);
        chk(reso, `CCRB_RST_RESONANCE);
        rdChk(`CCRB_OFF_MODE, `CCRB_RST_MODE);
        rdChk(`CCRB_OFF_CONTROL, `CCRB_RST_CONTROL);
        rdChk(`CCRB_OFF_RESONANCE, `CCRB_RST_RESONANCE);
        rdChk(`CCRB_OFF_CUR_LOW, 8'h00);
        $display("test_swreset done");
    endtask : test_swreset
    // thermal fault while active clears the setpoint registers
    task automatic test_fault();
        host_u.setCur(10'h155);
        idle(3);
        faultIn = 5'h10;
        idle(8);
        chk(setpoint, 10'h000);
        rdChk(`CCRB_OFF_CUR_LOW, 8'h00);
        rdChk(`CCRB_OFF_CUR_HIGH, 8'h00);
        chk(outEn, 1'b0);
        chk(modeState, ccrb_pkg::CCRB_STANDBY);
        rdChk(`CCRB_OFF_STATUS, 8'h10);
        faultIn = 5'h00;
        $display("test_fault done");
    endtask : test_fault
    task automatic tally_and_finish();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence after eight reset cycles
    initial begin
        idle(8);
        rst_n = 1'b1;
        idle(2);
        test_defaults();
        test_current();
        test_swreset();
        test_fault();
        tally_and_finish();
    end
    // watchdog well beyond the hundred or so cycles of the tests
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
